// [bench/cap_ctrl_props.sv]
// Concurrent checks on the capacity gauge, key and serial block ports
`timescale 1ns/100ps
module cap_ctrl_props #(
   parameter int FLICKER_HALF_CYC = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [6:0] capacity,
   input wire logic charging,
   input wire logic lowBattery,
   input wire cap_pkg::cap_led_cfg_t ledCount,
   input wire logic inFastCharge,
   input wire logic outFastCharge,
   input wire logic accessoryMode,
   input wire logic [4:0] ledOn,
   input wire logic voltage_set_fast_indicator_pin_out,
   input wire logic voltage_set_fast_indicator_pin_oe,
   input wire logic flashlight_or_accessory_data_pin_oe,
   input wire logic typeAEnable,
   input wire logic typeCEnable,
   input wire logic displayOn,
   input wire logic boostInhibit,
   input wire logic serialMode,
   input wire logic sdaOe,
   input wire logic regWrStrobe
);
   import cap_pkg::*;
   int runLen;
   logic lastLed;
   logic lastFlk;
   logic runOk;
   wire gauge = !lowBattery && !serialMode;
   wire flk = gauge && displayOn && !charging && capacity != 7'h00 && capacity < 7'h05;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Length of each steady run of the first LED while it flickers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         runLen <= 0;
         lastLed <= 1'b0;
         lastFlk <= 1'b0;
         runOk <= 1'b0;
      end else begin
         lastLed <= ledOn[0];
         lastFlk <= flk;
         runLen <= (ledOn[0] != lastLed) ? 1 : runLen + 1;
         runOk <= (ledOn[0] != lastLed) ? flk && lastFlk : runOk && flk;
      end
   end
   a_fast_pin_led:
   assert property (voltage_set_fast_indicator_pin_oe == (inFastCharge || outFastCharge)
      && voltage_set_fast_indicator_pin_out) else $error("fast charge pin wrong");
   a_boost_low_off:
   assert property (boostInhibit == lowBattery) else $error("boost inhibit wrong");
   a_flash_share:
   assert property (accessoryMode |-> !flashlight_or_accessory_data_pin_oe) else $error("pin shared");
   a_serial_dark:
   assert property (serialMode |-> ledOn == 5'h00) else $error("LED lit in serial mode");
   a_ack_serial_only:
   assert property (sdaOe || regWrStrobe |-> serialMode) else $error("bus active in LED mode");
   a_led_count_cap:
   assert property (ledCount != CAP_LEDS_5 |-> !ledOn[4] && (ledCount != CAP_LEDS_3 || !ledOn[3]))
      else $error("LED beyond count");
   a_gauge_full:
   assert property (gauge && displayOn && !charging && ledCount == CAP_LEDS_5 && capacity >= 7'h50
      |-> ledOn == 5'h1F) else $error("full gauge wrong");
   a_empty_dark:
   assert property (!lowBattery && !charging && capacity == 7'h00 |-> ledOn == 5'h00)
      else $error("empty gauge lit");
   a_charge_full:
   assert property (gauge && charging && capacity >= 7'h64 |-> ledOn == (ledCount == CAP_LEDS_3 ? 5'h07 :
      ledCount == CAP_LEDS_4 ? 5'h0F : 5'h1F)) else $error("charged gauge wrong");
   a_strobe_single:
   assert property (regWrStrobe |=> !regWrStrobe) else $error("strobe too long");
   a_short_enable:
   assert property ($rose(displayOn) |-> typeAEnable && typeCEnable) else $error("ports not enabled");
   a_double_off:
   assert property ($fell(typeAEnable) |-> !typeCEnable && !displayOn) else $error("ports not disabled");
   a_flicker_half:
   assert property (runOk && flk && ledOn[0] != lastLed |-> runLen == FLICKER_HALF_CYC)
      else $error("flicker half period wrong");
endmodule

bind cap_led_key_ctrl cap_ctrl_props #(.FLICKER_HALF_CYC(FLICKER_HALF_CYC)) i_cap_ctrl_props (
   .sys_clk, .nrst, .capacity, .charging, .lowBattery, .ledCount, .inFastCharge, .outFastCharge,
   .accessoryMode, .ledOn, .voltage_set_fast_indicator_pin_out, .voltage_set_fast_indicator_pin_oe,
   .flashlight_or_accessory_data_pin_oe, .typeAEnable, .typeCEnable, .displayOn, .boostInhibit,
   .serialMode, .sdaOe, .regWrStrobe);

// [bench/cap_i2c_host.sv]
// Serial bus host model on a pulled-up open-drain data line
`timescale 1ns/100ps
module cap_i2c_host (
   input wire logic sys_clk,
   input wire logic sdaOe,
   output logic sclIn,
   output logic sdaIn
);
   logic hostPull;
   int half = 125;
   // Released line floats high through the pull-up
   assign sdaIn = !(hostPull || sdaOe);
   initial begin
      sclIn = 1'b1;
      hostPull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic start();
      hostPull = 1'b0;
      tick(half);
      sclIn = 1'b1;
      tick(half);
      hostPull = 1'b1;
      tick(half);
      sclIn = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      hostPull = 1'b1;
      tick(half);
      sclIn = 1'b1;
      tick(half);
      hostPull = 1'b0;
      tick(half);
   endtask
   // one byte, most significant bit first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic hostAck, output logic [7:0] rx, output logic slvAck);
      logic [8:0] got;
      for (int i = 8; i >= 0; i--) begin
         hostPull = (i == 0) ? hostAck : !tx[i - 1];
         tick(half - 2);
         sclIn = 1'b1;
         tick(half);
         got = {got[7:0], sdaIn};
         sclIn = 1'b0;
         tick(2);
      end
      rx = got[8:1];
      slvAck = !got[0];
   endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the capacity gauge, key and serial block
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp); end end
module tb;
   import cap_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [6:0] capacity;
   cap_led_cfg_t ledCount;
   logic charging, lowBattery, inFastCharge, outFastCharge, keyPressed, accessoryMode, selPin;
   logic [4:0] ledOn;
   logic fastOut, fastOe, flashOut, flashOe, typeAEnable, typeCEnable, displayOn, boostInhibit;
   logic serialMode, sdaOut, sdaOe, regWrStrobe, sclIn, sdaIn, ack;
   logic [7:0] regAddr, regWrData, wrAddr, wrData, rx, andG, orG;
   logic [3:0] chgN, cnt;
   logic [7:0] capB, andE, orE;
   wire [7:0] regRdData = regAddr + 8'h11;
   int err_total = 0;
   int compares = 0;
   int wrCount = 0;
   int rises;
   logic lastLed;
   // Charge flag, LED count code, capacity, steady LEDs, lit-at-any-time LEDs
   logic [31:0] gTab [22] = '{32'h0264_1F1F, 32'h0250_1F1F, 32'h024F_0F0F, 32'h0228_0707, 32'h0214_0303,
      32'h0205_0101, 32'h0203_0001, 32'h0200_0000, 32'h014B_0F0F, 32'h0132_0707, 32'h0119_0303,
      32'h0118_0101, 32'h0042_0707, 32'h0021_0303, 32'h0020_0101, 32'h1264_1F1F, 32'h1255_0F1F,
      32'h120A_0001, 32'h113C_0307, 32'h1164_0F0F, 32'h1046_0307, 32'h1064_0707};
   cap_led_key_ctrl #(.FLICKER_HALF_CYC(8), .DEBOUNCE_CYC(2), .LONG_CYC(40), .GAP_CYC(20)) i_cap_led_key_ctrl (
      .sys_clk, .nrst, .ce, .capacity, .charging, .lowBattery, .ledCount, .inFastCharge,
      .outFastCharge, .keyPressed, .accessoryMode, .fourth_indicator_serial_select_pin(selPin), .sclIn,
      .sdaIn, .regRdData, .ledOn, .voltage_set_fast_indicator_pin_out(fastOut),
      .voltage_set_fast_indicator_pin_oe(fastOe), .flashlight_or_accessory_data_pin_out(flashOut),
      .flashlight_or_accessory_data_pin_oe(flashOe), .typeAEnable, .typeCEnable, .displayOn, .boostInhibit,
      .serialMode, .sdaOut, .sdaOe, .regAddr, .regWrData, .regWrStrobe);
   cap_i2c_host i_cap_i2c_host (.sys_clk, .sdaOe, .sclIn, .sdaIn);
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (regWrStrobe === 1'b1) begin
         wrCount++;
         wrAddr = regAddr;
         wrData = regWrData;
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic press(input int n);
      keyPressed = 1'b1;
      cyc(n);
      keyPressed = 1'b0;
      cyc(34);
   endtask
   task automatic doReset(input logic sel);
      nrst = 1'b0;
      selPin = sel;
      cyc(8);
      nrst = 1'b1;
      cyc(3);
   endtask
   task automatic endTest(input string name);
      $display("test %s finished", name);
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      {capacity, charging, lowBattery, inFastCharge, outFastCharge, keyPressed, accessoryMode} = '0;
      ledCount = CAP_LEDS_5;
      selPin = 1'b1;
      doReset(1'b1);
      `CHK(serialMode, 1'b0)
      `CHK(ledOn, 5'h00)
      press(5);
      `CHK({typeAEnable, typeCEnable, displayOn}, 3'h7)
      endTest("short press");
      foreach (gTab[k]) begin
         {chgN, cnt, capB, andE, orE} = gTab[k];
         charging = chgN[0];
         ledCount = cap_led_cfg_t'(cnt[1:0]);
         capacity = capB[6:0];
         cyc(2);
         andG = {3'h0, ledOn};
         orG = andG;
         repeat (25) begin
            cyc(1);
            andG = andG & {3'h0, ledOn};
            orG = orG | {3'h0, ledOn};
         end
         `CHK(andG, andE)
         `CHK(orG, orE)
      end
      endTest("gauge");
      {charging, capacity} = '0;
      cyc(2);
      lastLed = ledOn[0];
      rises = 0;
      lowBattery = 1'b1;
      cyc(1);
      `CHK(boostInhibit, 1'b1)
      repeat (120) begin
         if (ledOn[0] && !lastLed) rises++;
         lastLed = ledOn[0];
         cyc(1);
      end
      `CHK(rises, 5)
      lowBattery = 1'b0;
      cyc(1);
      `CHK(boostInhibit, 1'b0)
      endTest("low battery");
      press(60);
      `CHK({flashOut, flashOe}, 2'h3)
      accessoryMode = 1'b1;
      cyc(1);
      `CHK({flashOut, flashOe}, 2'h0)
      accessoryMode = 1'b0;
      press(60);
      `CHK(flashOut, 1'b0)
      endTest("long press");
      keyPressed = 1'b1;
      cyc(5);
      keyPressed = 1'b0;
      cyc(5);
      press(5);
      `CHK({typeAEnable, typeCEnable, displayOn}, 3'h0)
      endTest("double press");
      ce = 1'b0;
      press(5);
      ce = 1'b1;
      cyc(30);
      `CHK(displayOn, 1'b0)
      endTest("clock enable");
      for (int m = 0; m < 4; m++) begin
         {inFastCharge, outFastCharge} = m[1:0];
         cyc(1);
         `CHK({fastOut, fastOe}, {1'b1, m != 0})
      end
      endTest("fast charge pin");
      doReset(1'b0);
      `CHK({serialMode, sdaOut}, 2'h2)
      i_cap_i2c_host.start();
      i_cap_i2c_host.xfer(8'h7A, 1'b0, rx, ack);
      `CHK(ack, 1'b0)
      i_cap_i2c_host.stop();
      i_cap_i2c_host.start();
      i_cap_i2c_host.xfer(8'h78, 1'b0, rx, ack);
      `CHK(ack, 1'b1)
      i_cap_i2c_host.xfer(8'hB0, 1'b0, rx, ack);
      i_cap_i2c_host.xfer(8'h5A, 1'b0, rx, ack);
      `CHK({ack, wrAddr, wrData}, {1'b1, 16'hB05A})
      i_cap_i2c_host.xfer(8'h3C, 1'b0, rx, ack);
      `CHK({wrAddr, wrData}, 16'hB13C)
      i_cap_i2c_host.stop();
      `CHK(wrCount, 2)
      i_cap_i2c_host.half = 32;
      i_cap_i2c_host.start();
      i_cap_i2c_host.xfer(8'h78, 1'b0, rx, ack);
      i_cap_i2c_host.xfer(8'hB0, 1'b0, rx, ack);
      i_cap_i2c_host.start();
      i_cap_i2c_host.xfer(8'h79, 1'b0, rx, ack);
      `CHK(ack, 1'b1)
      i_cap_i2c_host.xfer(8'hFF, 1'b1, rx, ack);
      `CHK(rx, 8'hC1)
      i_cap_i2c_host.xfer(8'hFF, 1'b0, rx, ack);
      `CHK(rx, 8'hC2)
      `CHK(regAddr, 8'hB1)
      i_cap_i2c_host.stop();
      endTest("serial port");
      close_out();
   end
endmodule

// [rtl/cap_defs.svh]
// Constants for the capacity gauge, key and serial port block
`ifndef CAP_DEFS_SVH
`define CAP_DEFS_SVH

// Clock rate and time figures
`define CAP_CLK_KHZ 25000
`define CAP_FLICKER_HALF_MS 250
`define CAP_DEBOUNCE_MS 20
`define CAP_LONG_PRESS_MS 2000
`define CAP_DOUBLE_GAP_MS 300

// Capacity figures in percent
`define CAP_PCT_FULL 7'h64
`define CAP_PCT_LOW 7'h05
`define CAP_PCT_EMPTY 7'h00
`define CAP_PCT_NEVER 7'h7F
`define CAP_T5_1 7'h14
`define CAP_T5_2 7'h28
`define CAP_T5_3 7'h3C
`define CAP_T5_4 7'h50
`define CAP_T4_1 7'h19
`define CAP_T4_2 7'h32
`define CAP_T4_3 7'h4B
`define CAP_T3_1 7'h21
`define CAP_T3_2 7'h42

// LED counts
`define CAP_LEDS_MAX 5
`define CAP_N3 3'h3
`define CAP_N4 3'h4
`define CAP_N5 3'h5

// Low battery warning: five flickers, ten half periods
`define CAP_LOW_HALVES 4'hA

// Serial port
`define CAP_I2C_ADDR 7'h3C
`define CAP_BYTE_BITS 4'h8

`endif

// [rtl/cap_key_decoder.sv]
// Push key debounce and press classification
`timescale 1ns/100ps
`include "cap_defs.svh"
module cap_key_decoder #(
   parameter int DEBOUNCE_CYC = 1,
   parameter int LONG_CYC = 1,
   parameter int GAP_CYC = 1
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic keyPressed,
   output logic shortPress,
   output logic longPress,
   output logic doublePress
);
   import cap_pkg::*;

   localparam cap_timer_t DEB_LIM = cap_timer_t'(DEBOUNCE_CYC - 1);
   localparam cap_timer_t LONG_LIM = cap_timer_t'(LONG_CYC - 1);
   localparam cap_timer_t GAP_LIM = cap_timer_t'(GAP_CYC - 1);

   cap_key_state_t state;
   cap_timer_t debCnt;
   cap_timer_t holdCnt;
   logic keyStable;

   wire keyDiffers = keyPressed != keyStable;
   wire debDone = keyDiffers && debCnt == DEB_LIM;
   wire longHit = holdCnt == LONG_LIM;
   wire gapHit = holdCnt == GAP_LIM;

   // RULE_17: debounce filter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         debCnt <= '0;
         keyStable <= 1'b0;
      end else if (ce) begin
         debCnt <= (keyDiffers && !debDone) ? debCnt + 1'b1 : '0;
         if (debDone) begin
            keyStable <= keyPressed;
         end
      end
   end

   // RULE_08: short, long, double classification
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= KEY_IDLE;
         holdCnt <= '0;
         shortPress <= 1'b0;
         longPress <= 1'b0;
         doublePress <= 1'b0;
      end else if (ce) begin
         shortPress <= 1'b0;
         longPress <= 1'b0;
         doublePress <= 1'b0;
         holdCnt <= holdCnt + 1'b1;
         unique case (state)
            KEY_IDLE: begin
               holdCnt <= '0;
               if (keyStable) begin
                  state <= KEY_PRESS1;
               end
            end
            // RULE_17: hold time threshold
            KEY_PRESS1: begin
               if (!keyStable) begin
                  state <= KEY_GAP;
                  holdCnt <= '0;
               end else if (longHit) begin
                  longPress <= 1'b1;
                  state <= KEY_LONG;
               end
            end
            KEY_LONG: begin
               if (!keyStable) begin
                  state <= KEY_IDLE;
               end
            end
            // RULE_17: inter-press gap threshold
            KEY_GAP: begin
               if (keyStable) begin
                  state <= KEY_PRESS2;
               end else if (gapHit) begin
                  shortPress <= 1'b1;
                  state <= KEY_IDLE;
               end
            end
            KEY_PRESS2: begin
               if (!keyStable) begin
                  doublePress <= 1'b1;
                  state <= KEY_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// [rtl/cap_led_key_ctrl.sv]
// Capacity LED gauge, push key actions, fast-charge LED and serial slave port
//
// Behaviour
// RULE_01: Gauge supports three, four or five LEDs.
// RULE_02: Five LEDs discharging: one per 20% band.
// RULE_03: Five LEDs charging: flicker current band LED.
// RULE_04: Four LEDs use 25% bands, same patterns.
// RULE_05: Three LEDs use 33% and 66% limits.
// RULE_06: Low battery: five first-LED flickers, no boost.
// RULE_07: Fast-charge session drives indicator pin high.
// RULE_08: Key gives short, long, double press.
// RULE_09: Short press enables ports and display.
// RULE_10: Long press toggles flashlight driver.
// RULE_11: Double press disables ports and display.
// RULE_12: Serial port runs at 100K or 400K.
// RULE_13: Grounded select pin chooses serial port.
// RULE_14: Slave answers at 0x3C, register pointer first.
// RULE_15: Flashlight and accessory data never both.
// RULE_16: Flicker toggles at equal on/off times.
// RULE_17: Debounced key with hold and gap thresholds.
`timescale 1ns/100ps
`include "cap_defs.svh"
module cap_led_key_ctrl #(
   parameter int FLICKER_HALF_CYC = `CAP_FLICKER_HALF_MS * `CAP_CLK_KHZ,
   parameter int DEBOUNCE_CYC = `CAP_DEBOUNCE_MS * `CAP_CLK_KHZ,
   parameter int LONG_CYC = `CAP_LONG_PRESS_MS * `CAP_CLK_KHZ,
   parameter int GAP_CYC = `CAP_DOUBLE_GAP_MS * `CAP_CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [6:0] capacity,
   input wire logic charging,
   input wire logic lowBattery,
   input wire cap_pkg::cap_led_cfg_t ledCount,
   input wire logic inFastCharge,
   input wire logic outFastCharge,
   input wire logic keyPressed,
   input wire logic accessoryMode,
   input wire logic fourth_indicator_serial_select_pin,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic [7:0] regRdData,
   output logic [4:0] ledOn,
   output logic voltage_set_fast_indicator_pin_out,
   output logic voltage_set_fast_indicator_pin_oe,
   output logic flashlight_or_accessory_data_pin_out,
   output logic flashlight_or_accessory_data_pin_oe,
   output logic typeAEnable,
   output logic typeCEnable,
   output logic displayOn,
   output logic boostInhibit,
   output logic serialMode,
   output logic sdaOut,
   output logic sdaOe,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrStrobe
);
   import cap_pkg::*;
   localparam cap_timer_t FLICK_LIM = cap_timer_t'(FLICKER_HALF_CYC - 1);
   logic shortPress, longPress, doublePress, flashlight_driver, strapDone, flickPhase, lowPrev;
   cap_timer_t flickCnt;
   logic [3:0] lowHalves;

   cap_key_decoder #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_CYC(LONG_CYC), .GAP_CYC(GAP_CYC)) u_key (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .keyPressed(keyPressed),
      .shortPress(shortPress),
      .longPress(longPress),
      .doublePress(doublePress)
   );

   // Key actions and strap capture after reset release
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         typeAEnable <= 1'b0;
         typeCEnable <= 1'b0;
         displayOn <= 1'b0;
         flashlight_driver <= 1'b0;
         strapDone <= 1'b0;
         serialMode <= 1'b0;
      end else if (ce) begin
         // RULE_13: grounded select pin picks serial mode
         if (!strapDone) begin
            serialMode <= !fourth_indicator_serial_select_pin;
            strapDone <= 1'b1;
         end
         // RULE_09: short press turns on
         if (shortPress) begin
            typeAEnable <= 1'b1;
            typeCEnable <= 1'b1;
            displayOn <= 1'b1;
         // RULE_11: double press turns off
         end else if (doublePress) begin
            typeAEnable <= 1'b0;
            typeCEnable <= 1'b0;
            displayOn <= 1'b0;
         end
         // RULE_10: long press toggles flashlight
         if (longPress) begin
            flashlight_driver <= !flashlight_driver;
         end
      end
   end
   // RULE_15: pin serves flashlight only outside accessory mode
   assign flashlight_or_accessory_data_pin_out = flashlight_driver && !accessoryMode;
   assign flashlight_or_accessory_data_pin_oe = !accessoryMode;
   // RULE_07: fast-charge LED driven high, else released
   assign voltage_set_fast_indicator_pin_out = 1'b1;
   assign voltage_set_fast_indicator_pin_oe = inFastCharge || outFastCharge;
   // RULE_06: boost refused while battery is low
   assign boostInhibit = lowBattery;

   wire lowStart = (lowBattery && !lowPrev) || (lowBattery && shortPress);
   wire flickWrap = flickCnt == FLICK_LIM;

   // RULE_16: equal on and off half periods
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flickCnt <= '0;
         flickPhase <= 1'b1;
         lowHalves <= 4'h0;
         lowPrev <= 1'b0;
      end else if (ce) begin
         lowPrev <= lowBattery;
         if (lowStart) begin
            flickCnt <= '0;
            flickPhase <= 1'b1;
            // RULE_06: five flickers of the first LED
            lowHalves <= `CAP_LOW_HALVES;
         end else if (flickWrap) begin
            flickCnt <= '0;
            flickPhase <= !flickPhase;
            if (lowHalves != 4'h0) begin
               lowHalves <= lowHalves - 1'b1;
            end
         end else begin
            flickCnt <= flickCnt + 1'b1;
         end
      end
   end
   // RULE_01: band limits scale with LED count
   wire [6:0] thr1 = (ledCount == CAP_LEDS_5) ? `CAP_T5_1 : (ledCount == CAP_LEDS_4) ? `CAP_T4_1 : `CAP_T3_1;
   wire [6:0] thr2 = (ledCount == CAP_LEDS_5) ? `CAP_T5_2 : (ledCount == CAP_LEDS_4) ? `CAP_T4_2 : `CAP_T3_2;
   wire [6:0] thr3 = (ledCount == CAP_LEDS_5) ? `CAP_T5_3 : (ledCount == CAP_LEDS_4) ? `CAP_T4_3 : `CAP_PCT_NEVER;
   wire [6:0] thr4 = (ledCount == CAP_LEDS_5) ? `CAP_T5_4 : `CAP_PCT_NEVER;
   wire [2:0] numLeds = (ledCount == CAP_LEDS_5) ? `CAP_N5 : (ledCount == CAP_LEDS_4) ? `CAP_N4 : `CAP_N3;
   // RULE_04: 25% bands; RULE_05: 33% and 66% limits
   wire [2:0] band = {2'b00, capacity >= thr1} + {2'b00, capacity >= thr2} + {2'b00, capacity >= thr3}
      + {2'b00, capacity >= thr4};
   wire isFull = capacity >= `CAP_PCT_FULL;
   wire isEmpty = capacity == `CAP_PCT_EMPTY;
   wire isLow = capacity < `CAP_PCT_LOW;
   // RULE_02: discharge shows band+1 steady, 1-4% flickers first, 0% dark
   // RULE_03: charge shows band steady and flickers band LED, full all steady
   wire [2:0] steadyCnt = charging ? (isFull ? numLeds : band) : ((isEmpty || isLow) ? 3'h0 : band + 3'h1);
   wire flickEn = charging ? !isFull : (isLow && !isEmpty);
   wire [2:0] flickIdx = charging ? band : 3'h0;
   wire showGauge = (displayOn || charging) && !serialMode;
   wire lowActive = lowHalves != 4'h0;
   genvar i;
   generate
      for (i = 0; i < `CAP_LEDS_MAX; i++) begin : g_led
         wire inRange = 3'(i) < numLeds;
         wire steady = 3'(i) < steadyCnt;
         wire blink = flickEn && flickIdx == 3'(i) && flickPhase;
         wire lowBlink = (i == 0) && flickPhase;
         assign ledOn[i] = serialMode ? 1'b0 : lowActive ? lowBlink : (showGauge && inRange && (steady || blink));
      end
   endgenerate
   // RULE_12: bus rates far below clock
   cap_i2c_state_t i2cState;
   logic sclPrev, sdaPrev, readDir, ackOk;
   logic [3:0] bitCnt;
   logic [7:0] shifter;
   wire sclRise = sclIn && !sclPrev;
   wire sclFall = !sclIn && sclPrev;
   wire startCond = sclIn && sclPrev && sdaPrev && !sdaIn;
   wire stopCond = sclIn && sclPrev && !sdaPrev && sdaIn;
   wire byteDone = bitCnt == `CAP_BYTE_BITS;
   // RULE_14: slave address match
   wire addrHit = shifter[7:1] == `CAP_I2C_ADDR;
   wire shiftIn = i2cState == I2C_ADDR || i2cState == I2C_REG || i2cState == I2C_WDATA;
   assign sdaOut = 1'b0;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         i2cState <= I2C_IDLE;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         bitCnt <= 4'h0;
         shifter <= 8'h00;
         readDir <= 1'b0;
         ackOk <= 1'b0;
         sdaOe <= 1'b0;
         regAddr <= 8'h00;
         regWrData <= 8'h00;
         regWrStrobe <= 1'b0;
      end else if (ce) begin
         sclPrev <= sclIn;
         sdaPrev <= sdaIn;
         regWrStrobe <= 1'b0;
         if (!serialMode) begin
            i2cState <= I2C_IDLE;
            sdaOe <= 1'b0;
         end else if (startCond) begin
            i2cState <= I2C_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
         end else if (stopCond) begin
            i2cState <= I2C_IDLE;
            sdaOe <= 1'b0;
         end else if (sclRise) begin
            if (shiftIn) begin
               shifter <= {shifter[6:0], sdaIn};
               bitCnt <= bitCnt + 1'b1;
            end else if (i2cState == I2C_RDATA) begin
               bitCnt <= bitCnt + 1'b1;
            end else if (i2cState == I2C_RACK) begin
               ackOk <= !sdaIn;
               if (!sdaIn) begin
                  regAddr <= regAddr + 1'b1;
               end
            end
         end else if (sclFall) begin
            unique case (i2cState)
               I2C_ADDR: begin
                  if (byteDone) begin
                     i2cState <= addrHit ? I2C_AACK : I2C_IDLE;
                     sdaOe <= addrHit;
                     readDir <= shifter[0];
                  end
               end
               I2C_AACK: begin
                  bitCnt <= 4'h0;
                  if (readDir) begin
                     i2cState <= I2C_RDATA;
                     shifter <= regRdData;
                     sdaOe <= !regRdData[7];
                  end else begin
                     i2cState <= I2C_REG;
                     sdaOe <= 1'b0;
                  end
               end
               // RULE_14: register pointer follows slave address
               I2C_REG: begin
                  if (byteDone) begin
                     regAddr <= shifter;
                     i2cState <= I2C_RACKW;
                     sdaOe <= 1'b1;
                  end
               end
               I2C_RACKW: begin
                  i2cState <= I2C_WDATA;
                  bitCnt <= 4'h0;
                  sdaOe <= 1'b0;
               end
               I2C_WDATA: begin
                  if (byteDone) begin
                     regWrData <= shifter;
                     regWrStrobe <= 1'b1;
                     i2cState <= I2C_WACK;
                     sdaOe <= 1'b1;
                  end
               end
               I2C_WACK: begin
                  regAddr <= regAddr + 1'b1;
                  i2cState <= I2C_WDATA;
                  bitCnt <= 4'h0;
                  sdaOe <= 1'b0;
               end
               I2C_RDATA: begin
                  if (byteDone) begin
                     i2cState <= I2C_RACK;
                     sdaOe <= 1'b0;
                  end else begin
                     shifter <= {shifter[6:0], 1'b0};
                     sdaOe <= !shifter[6];
                  end
               end
               I2C_RACK: begin
                  bitCnt <= 4'h0;
                  i2cState <= ackOk ? I2C_RDATA : I2C_IDLE;
                  shifter <= regRdData;
                  sdaOe <= ackOk && !regRdData[7];
               end
               I2C_IDLE: begin
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// [rtl/cap_pkg.sv]
// Types shared by the capacity gauge, key and serial port block
package cap_pkg;
   typedef logic [26:0] cap_timer_t;
   typedef enum logic [1:0] {CAP_LEDS_3, CAP_LEDS_4, CAP_LEDS_5} cap_led_cfg_t;
   typedef enum {KEY_IDLE, KEY_PRESS1, KEY_LONG, KEY_GAP, KEY_PRESS2} cap_key_state_t;
   typedef enum {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_REG, I2C_RACKW, I2C_WDATA, I2C_WACK, I2C_RDATA,
      I2C_RACK} cap_i2c_state_t;
endpackage
